// *** hdl/i2cm_defs.svh ***
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

// register offsets
`define I2CM_ADDR_SEQ 2'h0
`define I2CM_ADDR_BUF 2'h1
`define I2CM_ADDR_STAT 2'h2
`define I2CM_ADDR_CFG 2'h3

// sequence control fields
`define I2CM_B_START 0
`define I2CM_B_RESTART 1
`define I2CM_B_STOP 2
`define I2CM_B_RECV 3
`define I2CM_B_ACKGO 4
`define I2CM_B_ACKVAL 5
`define I2CM_B_ACKRX 6
`define I2CM_B_GCE 7

// status and config fields
`define I2CM_S_BUSY 0
`define I2CM_S_FULL 1
`define I2CM_S_WCOL 2
`define I2CM_C_EN 0

// reset values
`define I2CM_RST_BYTE 8'h00
`define I2CM_RST_CMD 5'h00

// timing: quarter bit period, rounded up to whole cycles
`define I2CM_CLK_NS 4
`define I2CM_QTR_NS 2500
`define I2CM_QTR_CYC ((`I2CM_QTR_NS + `I2CM_CLK_NS - 1) / `I2CM_CLK_NS)

// bit counts and phases
`define I2CM_TX_LAST 4'h8
`define I2CM_RX_LAST 4'h7
`define I2CM_ONE_LAST 4'h0
`define I2CM_PH_LAST 2'h3
`define I2CM_PH_SAMPLE 2'h2
`define I2CM_PH_HIGH 2'h1
`define I2CM_PH_FIRST 2'h0

`endif

// *** hdl/i2cm_pkg.sv ***
package i2cm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_TX = 3'h3,
        ST_RX = 3'h2,
        ST_ACK = 3'h6,
        ST_STOP = 3'h7,
        ST_RESTART = 3'h5
    } i2cm_state_t;

    typedef logic [1:0] i2cm_phase_t;

endpackage : i2cm_pkg

// *** hdl/i2cm_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser, idles high like the bus
module i2cm_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level
    input wire logic din,
    output logic dout
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b1;
            dout <= 1'b1;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule : i2cm_sync

`default_nettype wire

// *** hdl/i2cm_tick.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "i2cm_defs.svh"

// quarter-bit tick; frozen while hold is high (clock stretch)
module i2cm_tick (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic run,
    input wire logic hold,
    output logic tick
);
    localparam logic [9:0] QTR_LAST = 10'(`I2CM_QTR_CYC - 1);

    logic [9:0] count;
    wire atLast = (count == QTR_LAST);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 10'h000;
            tick <= 1'b0;
        end else begin
            tick <= run && !hold && atLast;
            if (!run || atLast) begin
                count <= 10'h000;
            end else if (!hold) begin
                count <= count + 10'h001;
            end
        end
    end

endmodule : i2cm_tick

`default_nettype wire

// *** hdl/i2cm_master.sv ***
// Behaviour
// - ack go runs acknowledge, then self-clears
// - acknowledge drives the ack value bit
// - receive go clocks in one byte
// - restart go makes repeated start, self-clears
// - start go makes start, self-clears
// - busy port ignores commands, refuses buffer writes
`timescale 1ns/1ns
`default_nettype none
`include "i2cm_defs.svh"

module i2cm_master
    import i2cm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // data pin
    input wire logic dataPinIn,
    output logic dataPinOut,
    output logic dataPinOe,
    // clock pin
    input wire logic clockPinIn,
    output logic clockPinOut,
    output logic clockPinOe
);
    i2cm_state_t state, next_state;
    i2cm_phase_t phase;
    logic [3:0] bitCnt;
    logic [4:0] cmdBits;
    logic [7:0] shiftReg;
    logic [7:0] bufReg;
    logic ackValue;
    logic ackRx;
    logic genCall;
    logic enable;
    logic full;
    logic wcol;
    logic sdaIn;
    logic sclIn;
    logic tick;
    logic next_sdaOe;
    logic next_sclOe;

    // keep lowest set bit only
    function automatic logic [4:0] pick_first(input logic [4:0] x);
        pick_first = x & (5'h00 - x);
    endfunction : pick_first

    i2cm_sync u_syncSda (
        .clk(clk),
        .rst_b(rst_b),
        .din(dataPinIn),
        .dout(sdaIn)
    );

    i2cm_sync u_syncScl (
        .clk(clk),
        .rst_b(rst_b),
        .din(clockPinIn),
        .dout(sclIn)
    );

    wire idle = (state == ST_IDLE);
    // released clock still low: a slave is stretching
    wire stretch = !clockPinOe && !sclIn;

    i2cm_tick u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .run(!idle),
        .hold(stretch),
        .tick(tick)
    );

    // register decode
    wire seqWrite = wr && (addr == `I2CM_ADDR_SEQ);
    wire bufWrite = wr && (addr == `I2CM_ADDR_BUF);
    wire statWrite = wr && (addr == `I2CM_ADDR_STAT);
    wire cfgWrite = wr && (addr == `I2CM_ADDR_CFG);
    wire bufRead = rd && (addr == `I2CM_ADDR_BUF);
    wire canLaunch = idle && enable;
    wire [4:0] cmdPick = pick_first(wdata[4:0] & {5{seqWrite && canLaunch}});
    wire txLaunch = bufWrite && canLaunch;
    wire bufRefused = bufWrite && !idle;

    // sequence end
    wire [3:0] lastBit = (state == ST_TX) ? `I2CM_TX_LAST :
                         (state == ST_RX) ? `I2CM_RX_LAST : `I2CM_ONE_LAST;
    wire phaseEnd = tick && (phase == `I2CM_PH_LAST);
    wire seqDone = phaseEnd && (bitCnt == lastBit);
    wire sampleNow = tick && (phase == `I2CM_PH_SAMPLE);
    wire rxDone = seqDone && (state == ST_RX);
    // clock pulled low in the first and last quarter of every bit
    wire bitClockLow = (phase == `I2CM_PH_FIRST) || (phase == `I2CM_PH_LAST);

    wire [7:0] seqView = {genCall, ackRx, ackValue, cmdBits};
    wire [7:0] statView = {5'h00, wcol, full, !idle};
    wire [7:0] cfgView = {7'h00, enable};
    wire [7:0] readMux = (addr == `I2CM_ADDR_SEQ) ? seqView :
                         (addr == `I2CM_ADDR_BUF) ? bufReg :
                         (addr == `I2CM_ADDR_STAT) ? statView : cfgView;

    // state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cmdPick[`I2CM_B_START]) begin
                    next_state = ST_START;
                end else if (cmdPick[`I2CM_B_RESTART]) begin
                    next_state = ST_RESTART;
                end else if (cmdPick[`I2CM_B_STOP]) begin
                    next_state = ST_STOP;
                end else if (cmdPick[`I2CM_B_RECV]) begin
                    next_state = ST_RX;
                end else if (cmdPick[`I2CM_B_ACKGO]) begin
                    next_state = ST_ACK;
                end else if (txLaunch) begin
                    next_state = ST_TX;
                end
            end
            ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK: begin
                if (seqDone) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // pin drive; oe high pulls the line low
    always_comb begin
        next_sdaOe = dataPinOe;
        next_sclOe = clockPinOe;
        unique case (state)
            ST_IDLE: begin
                next_sdaOe = dataPinOe;
                next_sclOe = clockPinOe;
            end
            ST_START: begin
                next_sdaOe = (phase != `I2CM_PH_FIRST);
                next_sclOe = (phase == `I2CM_PH_LAST);
            end
            ST_RESTART: begin
                next_sdaOe = (phase >= `I2CM_PH_SAMPLE);
                next_sclOe = bitClockLow;
            end
            ST_STOP: begin
                next_sdaOe = (phase < `I2CM_PH_SAMPLE);
                next_sclOe = (phase == `I2CM_PH_FIRST);
            end
            ST_TX: begin
                next_sdaOe = (bitCnt != `I2CM_TX_LAST) && !shiftReg[7];
                next_sclOe = bitClockLow;
            end
            ST_RX: begin
                next_sdaOe = 1'b0;
                next_sclOe = bitClockLow;
            end
            ST_ACK: begin
                next_sdaOe = !ackValue;
                next_sclOe = bitClockLow;
            end
            default: begin
                next_sdaOe = 1'b0;
                next_sclOe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            dataPinOe <= 1'b0;
            clockPinOe <= 1'b0;
            dataPinOut <= 1'b0;
            clockPinOut <= 1'b0;
        end else begin
            state <= next_state;
            dataPinOe <= next_sdaOe;
            clockPinOe <= next_sclOe;
            dataPinOut <= 1'b0;
            clockPinOut <= 1'b0;
        end
    end

    // phase and bit counters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= `I2CM_PH_FIRST;
            bitCnt <= 4'h0;
        end else if (idle || seqDone) begin
            phase <= `I2CM_PH_FIRST;
            bitCnt <= 4'h0;
        end else if (phaseEnd) begin
            phase <= `I2CM_PH_FIRST;
            bitCnt <= bitCnt + 4'h1;
        end else if (tick) begin
            phase <= phase + 2'h1;
        end
    end

    // command bits: set only when idle, cleared by hardware at end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdBits <= `I2CM_RST_CMD;
        end else if (cmdPick != 5'h00) begin
            cmdBits <= cmdPick;
        end else if (seqDone) begin
            cmdBits <= `I2CM_RST_CMD;
        end
    end

    // software fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ackValue <= 1'b0;
            genCall <= 1'b0;
            enable <= 1'b0;
        end else begin
            if (seqWrite) begin
                ackValue <= wdata[`I2CM_B_ACKVAL];
                genCall <= wdata[`I2CM_B_GCE];
            end
            if (cfgWrite) begin
                enable <= wdata[`I2CM_C_EN];
            end
        end
    end

    // shifting, buffer and received acknowledge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shiftReg <= `I2CM_RST_BYTE;
            bufReg <= `I2CM_RST_BYTE;
            ackRx <= 1'b0;
        end else if (txLaunch) begin
            shiftReg <= wdata;
            bufReg <= wdata;
        end else if (state == ST_TX) begin
            if (sampleNow && bitCnt == `I2CM_TX_LAST) begin
                ackRx <= sdaIn;
            end
            if (phaseEnd) begin
                shiftReg <= {shiftReg[6:0], 1'b0};
            end
        end else if (state == ST_RX) begin
            if (sampleNow) begin
                shiftReg <= {shiftReg[6:0], sdaIn};
            end
            if (rxDone) begin
                bufReg <= shiftReg;
            end
        end
    end

    // status flags; a set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            full <= 1'b0;
            wcol <= 1'b0;
            rdata <= `I2CM_RST_BYTE;
        end else begin
            full <= rxDone || (full && !bufRead);
            wcol <= bufRefused || (wcol && !(statWrite && wdata[`I2CM_S_WCOL]));
            rdata <= rd ? readMux : `I2CM_RST_BYTE;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_busy_cmd_ignored: assert property (
        (!idle && seqWrite && !seqDone) |=> (cmdBits == $past(cmdBits)))
        else $error("command bits changed while busy");
    a_busy_buf_refused: assert property (
        (!idle && bufWrite && !rxDone) |=> (wcol && bufReg == $past(bufReg)))
        else $error("buffer write taken while busy");
    a_start_seq: assert property (
        (canLaunch && seqWrite && wdata[`I2CM_B_START])
        |=> (state == ST_START && cmdBits == 5'(1 << `I2CM_B_START)))
        else $error("start not launched");
    a_start_clear: assert property (
        (state == ST_START && seqDone) |=> (idle && cmdBits == `I2CM_RST_CMD && clockPinOe))
        else $error("start did not end cleanly");
    a_restart_clear: assert property (
        (state == ST_RESTART && seqDone) |=> (idle && !cmdBits[`I2CM_B_RESTART] && dataPinOe))
        else $error("restart bit not cleared");
    a_stop_release: assert property (
        (state == ST_STOP && seqDone)
        |=> idle ##1 (!dataPinOe && !clockPinOe && cmdBits == `I2CM_RST_CMD))
        else $error("stop did not release the bus");
    a_recv_byte: assert property (
        (state == ST_RX && seqDone)
        |=> (full && bufReg == $past(shiftReg) && !cmdBits[`I2CM_B_RECV]))
        else $error("received byte not stored");
    a_ack_drive: assert property (
        ($past(state) == ST_ACK && $past(phase) == `I2CM_PH_HIGH)
        |-> (dataPinOe == !$past(ackValue)))
        else $error("acknowledge value not driven");
    a_ack_clear: assert property (
        (state == ST_ACK && seqDone) |=> (idle && !cmdBits[`I2CM_B_ACKGO]))
        else $error("acknowledge bit not cleared");

    c_start_done: cover property (state == ST_START && seqDone);
    c_tx_done: cover property (state == ST_TX && seqDone);
    c_rx_done: cover property (rxDone);
    c_ack_done: cover property (state == ST_ACK && seqDone);

endmodule : i2cm_master

`default_nettype wire

// *** sim/i2cm_slave_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// bus slave on its own clock: sees start/stop, shifts in bits, acks, sends, stretches
module i2cm_slave_model (
    // own clock
    input wire logic sclk,
    // bus lines
    input wire logic clockLine,
    input wire logic dataLine,
    output logic dataOe,
    output logic clockOe,
    // behaviour: mode 0 listen, 1 ack a written byte, 2 send sendByte
    input wire logic [1:0] mode,
    input wire logic [7:0] sendByte,
    input wire logic stretch
);
    int edges = 0;
    int startCount = 0;
    int stopCount = 0;
    int holdCnt = 200;
    logic [8:0] shiftReg = 9'h000;
    logic prevClk = 1'b1;
    logic prevData = 1'b1;
    logic [1:0] prevMode = 2'h0;

    initial dataOe = 1'b0;
    initial clockOe = 1'b0;

    always @(posedge sclk) begin
        if (prevClk && clockLine && prevData && !dataLine) startCount++;
        if (prevClk && clockLine && !prevData && dataLine) stopCount++;
        if (!prevClk && clockLine) begin
            edges++;
            shiftReg <= {shiftReg[7:0], dataLine};
        end
        if (mode != prevMode) edges = 0;
        // data only moves while the clock line is low
        if (!clockLine) begin
            dataOe <= (mode == 2'h2 && edges < 8) ? !sendByte[7 - edges] :
                      (mode == 2'h1 && edges == 8);
        end
        // slow answer: hold the clock low past the master's low phase
        if (prevClk && !clockLine) holdCnt = 0;
        else if (holdCnt < 200) holdCnt++;
        clockOe <= stretch && holdCnt < 150;
        prevClk <= clockLine;
        prevData <= dataLine;
        prevMode <= mode;
    end
endmodule : i2cm_slave_model

`default_nettype wire

// *** sim/tb_i2c_master_sequence_control.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "i2cm_defs.svh"

module tb_i2c_master_sequence_control;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sclk = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] sendByte = 8'h00;
    logic stretch = 1'b0;
    wire [7:0] rdata;
    wire dataPinOut;
    wire dataPinOe;
    wire clockPinOut;
    wire clockPinOe;
    wire slvDataOe;
    wire slvClockOe;
    // open drain with pull-up
    wire dataLine = !(dataPinOe || slvDataOe);
    wire clockLine = !(clockPinOe || slvClockOe);
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seqModel = 0;
    logic [31:0] seed = 32'h0001265d;
    logic [7:0] got;
    logic [7:0] expQ[$];

    always #2 clk = !clk;
    initial begin
        #7;
        forever #24 sclk = !sclk;
    end

    i2cm_master i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .dataPinIn(dataLine), .dataPinOut(dataPinOut),
        .dataPinOe(dataPinOe), .clockPinIn(clockLine), .clockPinOut(clockPinOut),
        .clockPinOe(clockPinOe));
    i2cm_slave_model i_slave (.sclk(sclk), .clockLine(clockLine), .dataLine(dataLine),
        .dataOe(slvDataOe), .clockOe(slvClockOe), .mode(mode), .sendByte(sendByte),
        .stretch(stretch));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic go_cmd(input logic [7:0] v);
        wr_reg(`I2CM_ADDR_SEQ, v);
        seqModel = v & 8'ha0;
        rd_reg(`I2CM_ADDR_SEQ, got);
        check("seq busy", v, got);
    endtask : go_cmd

    task automatic done_cmd;
        int n;
        n = 0;
        got = 8'h01;
        while (got[0] !== 1'b0 && n < 20000) begin
            rd_reg(`I2CM_ADDR_STAT, got);
            n++;
        end
        check("busy drop", 8'h00, {7'h00, got[0]});
        rd_reg(`I2CM_ADDR_SEQ, got);
        check("seq idle", 8'(seqModel), got);
    endtask : done_cmd

    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fail_count++;
            $display("CHECK FAILED cycle limit expected below 90000 seen %0d", cycles);
            final_report();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(`I2CM_ADDR_SEQ, got);
        check("seq reset", 8'h00, got);
        rd_reg(`I2CM_ADDR_STAT, got);
        check("stat reset", 8'h00, got);
        // commands dropped while the port is disabled
        wr_reg(`I2CM_ADDR_SEQ, 8'h01);
        rd_reg(`I2CM_ADDR_SEQ, got);
        check("seq disabled", 8'h00, got);
        wr_reg(`I2CM_ADDR_CFG, 8'h01);
        go_cmd(8'h81);
        wr_reg(`I2CM_ADDR_SEQ, 8'h84);
        rd_reg(`I2CM_ADDR_SEQ, got);
        check("seq ignored", 8'h81, got);
        wr_reg(`I2CM_ADDR_BUF, 8'h5a);
        rd_reg(`I2CM_ADDR_STAT, got);
        check("write collision", 8'h05, got);
        rd_reg(`I2CM_ADDR_BUF, got);
        check("buf refused", 8'h00, got);
        wr_reg(`I2CM_ADDR_STAT, 8'h04);
        done_cmd();
        check("start seen", 8'h01, 8'(i_slave.startCount));
        seed = xorshift(seed);
        expQ.push_back(seed[7:0]);
        mode <= 2'h1;
        repeat (30) @(posedge clk);
        wr_reg(`I2CM_ADDR_BUF, seed[7:0]);
        done_cmd();
        check("slave byte", expQ.pop_front(), i_slave.shiftReg[8:1]);
        seed = xorshift(seed);
        expQ.push_back(seed[7:0]);
        sendByte <= seed[7:0];
        mode <= 2'h2;
        stretch <= 1'b1;
        repeat (30) @(posedge clk);
        go_cmd(8'h88);
        done_cmd();
        stretch <= 1'b0;
        mode <= 2'h0;
        rd_reg(`I2CM_ADDR_STAT, got);
        check("full", 8'h02, got);
        rd_reg(`I2CM_ADDR_BUF, got);
        check("rx byte", expQ.pop_front(), got);
        for (int k = 1; k >= 0; k--) begin
            go_cmd(k[0] ? 8'hb0 : 8'h90);
            done_cmd();
            check("ack bit", 8'(k), {7'h00, i_slave.shiftReg[0]});
        end
        go_cmd(8'h82);
        done_cmd();
        check("restart seen", 8'h02, 8'(i_slave.startCount));
        go_cmd(8'h84);
        done_cmd();
        check("stop seen", 8'h01, 8'(i_slave.stopCount));
        check("lines idle", 8'h03, {6'h00, clockLine, dataLine});
        check("pin out", 8'h00, {6'h00, clockPinOut, dataPinOut});
        // two command bits at once: only the lowest one runs
        wr_reg(`I2CM_ADDR_SEQ, 8'h0c);
        seqModel = 0;
        rd_reg(`I2CM_ADDR_SEQ, got);
        check("seq lowest", 8'h04, got);
        done_cmd();
        check("stop priority", 8'h02, 8'(i_slave.stopCount));
        final_report();
    end
endmodule : tb_i2c_master_sequence_control

`default_nettype wire
